// *** include/drive_protection_pkg.sv ***
// constants and types for the drive protection block
package drive_protection_pkg;
  // register offsets (byte address, word index = address / 4)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STALL_OV = 8'h04;
  localparam logic [7:0] ADDR_STALL_OC = 8'h08;
  localparam logic [7:0] ADDR_DERATE = 8'h0C;
  localparam logic [7:0] ADDR_RESET_CFG = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_HISTORY = 8'h18;
  localparam logic [7:0] ADDR_SNAP_FREQ = 8'h1C;
  localparam logic [7:0] ADDR_SNAP_IV = 8'h20;
  localparam logic [7:0] ADDR_SNAP_BUS = 8'h24;
  localparam logic [7:0] ADDR_ALLOWED = 8'h28;
  localparam logic [7:0] ADDR_COMMAND = 8'h2C;
  // control register fields
  localparam int CTRL_OVP_LSB = 0;
  localparam int CTRL_PHL_LSB = 2;
  localparam int CTRL_CLASS_BIT = 4;
  localparam int CTRL_DUTY_LSB = 8;
  // command register bits
  localparam int CMD_MANUAL_RESET = 0;
  localparam int CMD_PARAM_INIT = 1;
  // reset values and fixed levels
  localparam logic [1:0] OVP_SEL_RST = 2'h0;
  localparam logic [1:0] PHL_SEL_RST = 2'h3;
  localparam logic [6:0] DUTY_RST = 7'h64;
  localparam logic [9:0] STALL_OV_RST_200 = 10'h186; // 390 V
  localparam logic [9:0] STALL_OV_RST_400 = 10'h375; // 885 V
  localparam logic [11:0] STALL_OC_RST = 12'h7D0;    // 200.0 %
  localparam logic [14:0] DERATE_FREQ_RST = 15'h09C4; // 25.00 Hz
  localparam logic [9:0] STANDSTILL_RST = 10'h0FA;   // 25.0 %
  localparam logic [1:0] RETRY_CNT_RST = 2'h0;
  localparam logic [5:0] RETRY_SEC_RST = 6'h0A;
  localparam logic [9:0] FULL_LOAD = 10'h3E8;        // 100.0 %
  localparam logic [9:0] INPUT_LOSS_MIN = 10'h12C;   // 30.0 %
  localparam logic [14:0] OUT_LOSS_MIN_FREQ = 15'h0064; // 1.00 Hz
  localparam logic [9:0] HYST_200 = 10'h00A;
  localparam logic [9:0] HYST_400 = 10'h00F;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int WINDOW_US = 10000;
  localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
  localparam int SECOND_MS = 1000;
  localparam int SECOND_CYC = SECOND_MS * 1000 * CLK_MHZ;
  // phase loss fault codes, never eligible for automatic restart
  localparam logic [5:0] FAULT_IN_PHASE = 6'h20;
  localparam logic [5:0] FAULT_OUT_PHASE = 6'h21;
  typedef enum logic [1:0] {
    RAMP_NORMAL = 2'b00,
    RAMP_HOLD = 2'b01,
    RAMP_DECEL = 2'b10
  } ramp_cmd_e;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_LOCKED = 2'b10
  } fault_state_e;
endpackage

// *** logic/drive_protection_control.sv ***
// protection, stall limiting and fault handling for a motor drive
`timescale 1ns/1ps
module drive_protection_control
  import drive_protection_pkg::*;
#(
  parameter int WINDOW_CYCLES = WINDOW_CYC,
  parameter int SECOND_CYCLES = SECOND_CYC
)(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [9:0] i_bus_voltage,
  input wire logic [9:0] i_output_voltage,
  input wire logic [11:0] i_output_current,
  input wire logic [14:0] i_output_frequency,
  input wire logic [14:0] i_set_frequency,
  input wire logic [7:0] i_module_temperature,
  input wire logic i_accelerating,
  input wire logic i_decelerating,
  input wire logic i_run_cmd,
  input wire logic i_dc_braking,
  input wire logic i_speed_search,
  input wire logic i_auto_tuning,
  input wire logic i_input_loss_detect,
  input wire logic i_output_loss_detect,
  input wire logic i_fault,
  input wire logic [5:0] i_fault_code,
  input wire logic i_fault_auto_class,
  output logic [31:0] o_rdata,
  output logic o_chopper_on,
  output logic [1:0] o_ramp_cmd,
  output logic o_output_stop,
  output logic o_internal_run,
  output logic o_input_phase_loss_fault,
  output logic o_output_phase_loss_fault,
  output logic [5:0] o_error_code
);

  // configuration registers
  logic [1:0] overvoltage_prevention_select_ff;
  logic [1:0] phase_loss_select_ff;
  logic class_400_ff;
  logic [6:0] brake_max_duty_ff;
  logic [9:0] stall_overvoltage_level_ff;
  logic [11:0] stall_overcurrent_level_ff;
  logic [14:0] derating_corner_frequency_ff;
  logic [9:0] standstill_load_percent_ff;
  logic [1:0] auto_reset_count_ff;
  logic [5:0] auto_reset_interval_ff;
  // history and snapshots
  logic [5:0] fault_history_last_ff;
  logic [5:0] fault_history_second_ff;
  logic [5:0] fault_history_third_ff;
  logic [14:0] snapshot_output_frequency_ff;
  logic [14:0] snapshot_set_frequency_ff;
  logic [11:0] snapshot_output_current_ff;
  logic [9:0] snapshot_output_voltage_ff;
  logic [9:0] snapshot_bus_voltage_ff;
  logic [7:0] snapshot_module_temperature_ff;
  // runtime state
  logic chop_hyst_ff;
  logic [31:0] win_cnt_ff;
  logic [31:0] on_cnt_ff;
  logic [31:0] sec_cnt_ff;
  logic [5:0] wait_sec_ff;
  logic [1:0] tries_ff;
  logic fault_seen_ff;
  logic [9:0] allowed_ff;
  fault_state_e state_ff;

  wire wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
  wire wr_cmd = i_wr && (i_addr == ADDR_COMMAND);
  wire manual_reset = wr_cmd && i_wdata[CMD_MANUAL_RESET];
  wire param_init = wr_cmd && i_wdata[CMD_PARAM_INIT];

  // protection mode decode
  wire stall_en = (overvoltage_prevention_select_ff == 2'h1);
  wire brake_en = (overvoltage_prevention_select_ff == 2'h2);
  wire in_sup_en = (phase_loss_select_ff == 2'h0) ||
                   (phase_loss_select_ff == 2'h1);
  wire out_sup_en = (phase_loss_select_ff == 2'h0) ||
                    (phase_loss_select_ff == 2'h2);

  // chopper hysteresis
  wire [9:0] hyst = class_400_ff ? HYST_400 : HYST_200;
  wire [9:0] chop_off_lvl = stall_overvoltage_level_ff - hyst;
  wire nxt_chop_hyst = (i_bus_voltage >= stall_overvoltage_level_ff) ? 1'b1 :
                       (i_bus_voltage < chop_off_lvl) ? 1'b0 : chop_hyst_ff;
  // duty limit per window
  wire [63:0] on_limit_w = (64'(WINDOW_CYCLES) * 64'(brake_max_duty_ff)) / 64'd100;
  wire full_duty = (brake_max_duty_ff >= 7'h64);
  wire win_end = (win_cnt_ff == 32'(WINDOW_CYCLES - 1));
  wire duty_ok = full_duty || (64'(on_cnt_ff) < on_limit_w);
  wire chop_next = brake_en && nxt_chop_hyst && duty_ok;

  // stall handling
  wire ov_stall = stall_en && i_decelerating &&
                  (i_bus_voltage > stall_overvoltage_level_ff);
  wire oc_over = (i_output_current > stall_overcurrent_level_ff);
  wire const_speed = !i_accelerating && !i_decelerating && i_run_cmd;
  logic [1:0] nxt_ramp;
  always_comb
  begin
    nxt_ramp = RAMP_NORMAL;
    if (ov_stall)
      nxt_ramp = RAMP_HOLD;
    else if (i_accelerating && oc_over)
      nxt_ramp = RAMP_HOLD;
    else if (const_speed && oc_over)
      nxt_ramp = RAMP_DECEL;
  end

  // low speed derating: allowed = load0 + (100 - load0) * f / fcorner
  wire [31:0] derate_span = 32'(FULL_LOAD - standstill_load_percent_ff);
  wire [31:0] derate_num = derate_span * 32'(i_output_frequency);
  wire [31:0] derate_add = derate_num / 32'(derating_corner_frequency_ff);
  wire [9:0] nxt_allowed =
    (i_output_frequency >= derating_corner_frequency_ff) ? FULL_LOAD :
    standstill_load_percent_ff + derate_add[9:0];

  // phase loss qualification
  wire cur_pct_ok = (i_output_current >= 12'(INPUT_LOSS_MIN));
  wire in_loss = in_sup_en && i_input_loss_detect && i_run_cmd &&
                 cur_pct_ok && !i_decelerating;
  wire out_loss = out_sup_en && i_output_loss_detect &&
                  (i_output_frequency >= OUT_LOSS_MIN_FREQ) &&
                  !i_dc_braking && !i_speed_search && !i_auto_tuning;

  // fault sequencing
  wire fault_any = i_fault || in_loss || out_loss;
  wire [5:0] new_code = in_loss ? FAULT_IN_PHASE :
                        out_loss ? FAULT_OUT_PHASE : i_fault_code;
  wire auto_ok = (auto_reset_count_ff != 2'h0) && i_fault_auto_class &&
                 !in_loss && !out_loss;
  wire fault_edge = fault_any && !fault_seen_ff && (state_ff == ST_RUN);
  wire sec_tick = (sec_cnt_ff == 32'(SECOND_CYCLES - 1));
  wire wait_done = sec_tick && (wait_sec_ff == auto_reset_interval_ff - 6'h01);

  fault_state_e nxt_state;
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN:
        if (fault_edge)
          nxt_state = (auto_ok && tries_ff < auto_reset_count_ff) ?
                      ST_WAIT : ST_LOCKED;
      ST_WAIT:
        if (wait_done)
          nxt_state = ST_RUN;
      ST_LOCKED:
        if (manual_reset)
          nxt_state = ST_RUN;
      default:
        nxt_state = ST_RUN;
    endcase
  end

  // configuration writes
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || param_init)
    begin
      overvoltage_prevention_select_ff <= OVP_SEL_RST;
      phase_loss_select_ff <= PHL_SEL_RST;
      class_400_ff <= 1'b0;
      brake_max_duty_ff <= DUTY_RST;
      stall_overvoltage_level_ff <= STALL_OV_RST_200;
      stall_overcurrent_level_ff <= STALL_OC_RST;
      derating_corner_frequency_ff <= DERATE_FREQ_RST;
      standstill_load_percent_ff <= STANDSTILL_RST;
      auto_reset_count_ff <= RETRY_CNT_RST;
      auto_reset_interval_ff <= RETRY_SEC_RST;
    end
    else if (i_wr)
    begin
      if (wr_ctrl)
      begin
        if (i_wdata[CTRL_OVP_LSB +: 2] != 2'h3)
          overvoltage_prevention_select_ff <= i_wdata[CTRL_OVP_LSB +: 2];
        phase_loss_select_ff <= i_wdata[CTRL_PHL_LSB +: 2];
        class_400_ff <= i_wdata[CTRL_CLASS_BIT];
        if (i_wdata[CTRL_DUTY_LSB +: 7] <= DUTY_RST)
          brake_max_duty_ff <= i_wdata[CTRL_DUTY_LSB +: 7];
        // class change reloads the class default level
        if (i_wdata[CTRL_CLASS_BIT] != class_400_ff)
          stall_overvoltage_level_ff <= i_wdata[CTRL_CLASS_BIT] ?
                                        STALL_OV_RST_400 : STALL_OV_RST_200;
      end
      if (i_addr == ADDR_STALL_OV)
        stall_overvoltage_level_ff <= i_wdata[9:0];
      if (i_addr == ADDR_STALL_OC)
        stall_overcurrent_level_ff <= i_wdata[11:0];
      if (i_addr == ADDR_DERATE)
      begin
        if (i_wdata[14:0] != 15'h0000)
          derating_corner_frequency_ff <= i_wdata[14:0];
        standstill_load_percent_ff <= i_wdata[25:16];
      end
      if (i_addr == ADDR_RESET_CFG)
      begin
        auto_reset_count_ff <= i_wdata[1:0];
        auto_reset_interval_ff <= i_wdata[13:8];
      end
    end
  end

  // fault history and snapshots
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || param_init)
    begin
      fault_history_last_ff <= 6'h00;
      fault_history_second_ff <= 6'h00;
      fault_history_third_ff <= 6'h00;
      snapshot_output_frequency_ff <= 15'h0000;
      snapshot_set_frequency_ff <= 15'h0000;
      snapshot_output_current_ff <= 12'h000;
      snapshot_output_voltage_ff <= 10'h000;
      snapshot_bus_voltage_ff <= 10'h000;
      snapshot_module_temperature_ff <= 8'h00;
    end
    else if (fault_edge)
    begin
      fault_history_third_ff <= fault_history_second_ff;
      fault_history_second_ff <= fault_history_last_ff;
      fault_history_last_ff <= new_code;
      snapshot_output_frequency_ff <= i_output_frequency;
      snapshot_set_frequency_ff <= i_set_frequency;
      snapshot_output_current_ff <= i_output_current;
      snapshot_output_voltage_ff <= i_output_voltage;
      snapshot_bus_voltage_ff <= i_bus_voltage;
      snapshot_module_temperature_ff <= i_module_temperature;
    end
  end

  // chopper, ramp and derating
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      chop_hyst_ff <= 1'b0;
      win_cnt_ff <= 32'h0000_0000;
      on_cnt_ff <= 32'h0000_0000;
      o_chopper_on <= 1'b0;
      o_ramp_cmd <= RAMP_NORMAL;
      allowed_ff <= FULL_LOAD;
    end
    else
    begin
      chop_hyst_ff <= nxt_chop_hyst;
      win_cnt_ff <= win_end ? 32'h0000_0000 : win_cnt_ff + 32'h0000_0001;
      if (win_end)
        on_cnt_ff <= 32'h0000_0000;
      else if (chop_next)
        on_cnt_ff <= on_cnt_ff + 32'h0000_0001;
      o_chopper_on <= chop_next;
      o_ramp_cmd <= nxt_ramp;
      allowed_ff <= nxt_allowed;
    end
  end

  // fault state machine and phase loss flags
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_ff <= ST_RUN;
      fault_seen_ff <= 1'b0;
      sec_cnt_ff <= 32'h0000_0000;
      wait_sec_ff <= 6'h00;
      tries_ff <= 2'h0;
      o_output_stop <= 1'b0;
      o_internal_run <= 1'b0;
      o_input_phase_loss_fault <= 1'b0;
      o_output_phase_loss_fault <= 1'b0;
      o_error_code <= 6'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      fault_seen_ff <= fault_any;
      if (state_ff == ST_WAIT && !sec_tick)
        sec_cnt_ff <= sec_cnt_ff + 32'h0000_0001;
      else
        sec_cnt_ff <= 32'h0000_0000;
      if (state_ff != ST_WAIT)
        wait_sec_ff <= 6'h00;
      else if (sec_tick)
        wait_sec_ff <= wait_sec_ff + 6'h01;
      if (fault_edge && nxt_state == ST_WAIT)
        tries_ff <= tries_ff + 2'h1;
      else if (manual_reset)
        tries_ff <= 2'h0;
      o_output_stop <= (nxt_state != ST_RUN);
      o_internal_run <= (state_ff == ST_WAIT) && wait_done;
      if (fault_edge)
        o_error_code <= new_code;
      else if (nxt_state == ST_RUN && state_ff != ST_RUN)
        o_error_code <= 6'h00;
      // set wins over manual clear
      if (in_loss)
        o_input_phase_loss_fault <= 1'b1;
      else if (manual_reset)
        o_input_phase_loss_fault <= 1'b0;
      if (out_loss)
        o_output_phase_loss_fault <= 1'b1;
      else if (manual_reset)
        o_output_phase_loss_fault <= 1'b0;
    end
  end

  // register read port
  logic [31:0] rd_mux;
  always_comb
  begin
    case (i_addr)
      ADDR_CTRL: rd_mux = {16'h0000, 1'b0, brake_max_duty_ff, 3'h0,
                           class_400_ff, phase_loss_select_ff,
                           overvoltage_prevention_select_ff};
      ADDR_STALL_OV: rd_mux = {22'h000000, stall_overvoltage_level_ff};
      ADDR_STALL_OC: rd_mux = {20'h00000, stall_overcurrent_level_ff};
      ADDR_DERATE: rd_mux = {6'h00, standstill_load_percent_ff, 1'b0,
                             derating_corner_frequency_ff};
      ADDR_RESET_CFG: rd_mux = {18'h00000, auto_reset_interval_ff,
                                6'h00, auto_reset_count_ff};
      ADDR_STATUS: rd_mux = {16'h0000, o_error_code, tries_ff,
                             state_ff, o_output_phase_loss_fault,
                             o_input_phase_loss_fault, o_ramp_cmd,
                             o_chopper_on, o_output_stop};
      ADDR_HISTORY: rd_mux = {8'h00, 2'h0, fault_history_third_ff,
                              2'h0, fault_history_second_ff,
                              2'h0, fault_history_last_ff};
      ADDR_SNAP_FREQ: rd_mux = {1'b0, snapshot_set_frequency_ff,
                                1'b0, snapshot_output_frequency_ff};
      ADDR_SNAP_IV: rd_mux = {6'h00, snapshot_output_voltage_ff,
                              4'h0, snapshot_output_current_ff};
      ADDR_SNAP_BUS: rd_mux = {14'h0000, snapshot_module_temperature_ff,
                               snapshot_bus_voltage_ff};
      ADDR_ALLOWED: rd_mux = {22'h000000, allowed_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_rdata <= 32'h0000_0000;
    else if (i_rd)
      o_rdata <= rd_mux;
    else
      o_rdata <= 32'h0000_0000;
  end

endmodule // drive_protection_control

// *** tb/drive_protection_control_properties.sv ***
// assertion checker for the drive protection block
`timescale 1ns/1ps
module drive_protection_control_properties
  import drive_protection_pkg::*;
#(
  parameter int WINDOW_CYCLES = WINDOW_CYC,
  parameter int SECOND_CYCLES = SECOND_CYC
)(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_fault,
  input wire logic [9:0] i_bus_voltage,
  input wire logic [11:0] i_output_current,
  input wire logic [14:0] i_output_frequency,
  input wire logic i_accelerating,
  input wire logic i_decelerating,
  input wire logic i_run_cmd,
  input wire logic i_dc_braking,
  input wire logic i_speed_search,
  input wire logic i_auto_tuning,
  input wire logic i_input_loss_detect,
  input wire logic i_output_loss_detect,
  input wire logic o_chopper_on,
  input wire logic [1:0] o_ramp_cmd,
  input wire logic o_output_stop,
  input wire logic o_internal_run,
  input wire logic o_input_phase_loss_fault,
  input wire logic o_output_phase_loss_fault,
  input wire logic [5:0] o_error_code
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // length of the current stop phase
  logic [31:0] stop_cnt_ff;
  logic [31:0] nxt_stop_cnt;
  assign nxt_stop_cnt = o_output_stop ? stop_cnt_ff + 32'h1 : 32'h0;
  always_ff @(posedge i_clk)
    if (!i_rst_n)
      stop_cnt_ff <= 32'h0;
    else
      stop_cnt_ff <= nxt_stop_cnt;
  run_pulse_single_a: assert property (
    o_internal_run |=> !o_internal_run) else $error("run pulse too long");
  restart_clears_a: assert property (
    o_internal_run |-> ##[0:1] (!o_output_stop && o_error_code == 6'h00))
    else $error("restart left output stopped");
  fault_stops_a: assert property (
    $rose(i_fault) && !o_output_stop && !o_internal_run |=> o_output_stop)
    else $error("fault did not stop output");
  restart_interval_a: assert property (
    o_internal_run |-> stop_cnt_ff >= 32'(2 * SECOND_CYCLES - 2))
    else $error("restart before minimum interval");
  code_needs_stop_a: assert property (
    o_error_code != 6'h00 |-> o_output_stop) else $error("code while running");
  ramp_hold_cause_a: assert property (
    o_ramp_cmd == RAMP_HOLD |-> $past(i_accelerating) || $past(i_decelerating))
    else $error("hold outside a ramp");
  ramp_decel_cause_a: assert property (
    o_ramp_cmd == RAMP_DECEL |-> !$past(i_accelerating)
      && !$past(i_decelerating) && $past(i_output_current) > 12'h0C8)
    else $error("stall decel without cause");
  chop_low_bus_a: assert property (
    $past(i_bus_voltage) < 10'h100 |-> !o_chopper_on)
    else $error("chopper on at low bus");
  in_loss_gate_a: assert property (
    $rose(o_input_phase_loss_fault) |-> $past(i_input_loss_detect)
      && $past(i_run_cmd) && !$past(i_decelerating)
      && $past(i_output_current) >= 12'(INPUT_LOSS_MIN))
    else $error("input loss flagged while masked");
  out_loss_gate_a: assert property (
    $rose(o_output_phase_loss_fault) |-> $past(i_output_loss_detect)
      && $past(i_output_frequency) >= OUT_LOSS_MIN_FREQ && !$past(i_dc_braking)
      && !$past(i_speed_search) && !$past(i_auto_tuning))
    else $error("output loss flagged while masked");
endmodule // drive_protection_control_properties

bind drive_protection_control drive_protection_control_properties #(
  .WINDOW_CYCLES(WINDOW_CYCLES),
  .SECOND_CYCLES(SECOND_CYCLES)
) u_drive_protection_control_properties (
  .i_clk, .i_rst_n, .i_fault, .i_bus_voltage, .i_output_current,
  .i_output_frequency, .i_accelerating, .i_decelerating, .i_run_cmd,
  .i_dc_braking, .i_speed_search, .i_auto_tuning, .i_input_loss_detect,
  .i_output_loss_detect, .o_chopper_on, .o_ramp_cmd, .o_output_stop,
  .o_internal_run, .o_input_phase_loss_fault, .o_output_phase_loss_fault,
  .o_error_code
);

// *** tb/drive_protection_control_tb.sv ***
// self-checking bench for the drive protection block
`timescale 1ns/1ps
module drive_protection_control_tb import drive_protection_pkg::*;;
  logic i_clk, i_rst_n, i_wr, i_rd, i_accelerating, i_decelerating, i_run_cmd;
  logic i_dc_braking, i_speed_search, i_auto_tuning, i_input_loss_detect;
  logic i_output_loss_detect, i_fault, i_fault_auto_class, o_chopper_on;
  logic o_output_stop, o_internal_run, o_input_phase_loss_fault;
  logic o_output_phase_loss_fault;
  logic [7:0] i_addr, i_module_temperature;
  logic [31:0] i_wdata, o_rdata;
  logic [9:0] i_bus_voltage, i_output_voltage;
  logic [11:0] i_output_current;
  logic [14:0] i_output_frequency, i_set_frequency;
  logic [5:0] i_fault_code, o_error_code;
  logic [1:0] o_ramp_cmd;
  int fails = 0, n_compared = 0, cyc = 0, seed = 52594, v, n, i, k, b, c;
  drive_protection_control #(.WINDOW_CYCLES(100), .SECOND_CYCLES(10))
  u_drive_protection_control (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr,
    .i_rd, .i_bus_voltage, .i_output_voltage, .i_output_current,
    .i_output_frequency, .i_set_frequency, .i_module_temperature,
    .i_accelerating, .i_decelerating, .i_run_cmd, .i_dc_braking,
    .i_speed_search, .i_auto_tuning, .i_input_loss_detect,
    .i_output_loss_detect, .i_fault, .i_fault_code, .i_fault_auto_class,
    .o_rdata, .o_chopper_on, .o_ramp_cmd, .o_output_stop, .o_internal_run,
    .o_input_phase_loss_fault, .o_output_phase_loss_fault, .o_error_code);
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task final_report;
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      final_report;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task settle(input int t);
    repeat (t) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, e);
  endtask
  function logic [31:0] ctrl(input int s, input int p, input int l, input int d);
    return {17'h0, 7'(d), 3'h0, 1'(l), 2'(p), 2'(s)};
  endfunction
  function logic [1:0] exp_ramp(input int m, input int s, input int u, input int w);
    if (m == 2)
      return (s == 1 && w > 390) ? RAMP_HOLD : RAMP_NORMAL;
    if (u > 2000)
      return (m == 1) ? RAMP_HOLD : RAMP_DECEL;
    return RAMP_NORMAL;
  endfunction
  task chop(input int w, input logic e);
    @(posedge i_clk);
    i_bus_voltage <= 10'(w);
    settle(3);
    chk(o_chopper_on, e);
  endtask
  task count_on;
    n = 0;
    repeat (200) @(negedge i_clk) n += int'(o_chopper_on);
  endtask
  task ploss(input int p, input logic li, input logic lo, input logic ei,
             input logic eo);
    wr(ADDR_CTRL, ctrl(0, p, 0, 100));
    @(posedge i_clk);
    i_input_loss_detect <= li;
    i_output_loss_detect <= lo;
    settle(4);
    chk({o_input_phase_loss_fault, o_output_phase_loss_fault, o_output_stop,
      o_error_code}, {ei, eo, ei | eo, ei ? FAULT_IN_PHASE : eo ?
      FAULT_OUT_PHASE : 6'h00});
    @(posedge i_clk);
    i_input_loss_detect <= 1'b0;
    i_output_loss_detect <= 1'b0;
    wr(ADDR_COMMAND, 32'h1);
    settle(2);
    chk({o_input_phase_loss_fault, o_output_phase_loss_fault}, 0);
  endtask
  task flt(input logic [5:0] f, input logic a);
    @(posedge i_clk);
    i_fault_code <= f;
    i_fault_auto_class <= a;
    i_fault <= 1'b1;
    @(posedge i_clk);
    i_fault <= 1'b0;
    settle(1);
    chk({o_output_stop, o_error_code}, {1'b1, f});
    n = 0;
    while (n < 60 && !o_internal_run)
    begin
      @(negedge i_clk);
      n++;
    end
  endtask
  initial
  begin
    {i_wr, i_rd, i_accelerating, i_decelerating, i_run_cmd, i_dc_braking} = 0;
    {i_speed_search, i_auto_tuning, i_input_loss_detect, i_fault} = 0;
    {i_output_loss_detect, i_fault_auto_class, i_addr, i_wdata} = 0;
    {i_bus_voltage, i_output_voltage, i_output_current, i_fault_code} = 0;
    {i_output_frequency, i_module_temperature} = 0;
    i_set_frequency = 15'h0BB8;
    i_rst_n = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wr(ADDR_CTRL, ctrl(3, 3, 0, 100));
    rchk(ADDR_CTRL, 32'h0000640C);
    rchk(ADDR_STALL_OV, 32'h00000186);
    rchk(ADDR_STALL_OC, 32'h000007D0);
    rchk(ADDR_DERATE, 32'h00FA09C4);
    rchk(ADDR_RESET_CFG, 32'h00000A00);
    wr(ADDR_HISTORY, 32'hFFFFFFFF);
    rchk(ADDR_HISTORY, 32'h0);
    rchk(8'h30, 32'h0);
    for (i = 0; i < 24; i++)
    begin
      v = $random(seed);
      k = int'(v[1:0]) % 3;
      n = int'(v[3:2]) % 3;
      b = 380 + int'(v[8:4]) % 22;
      c = 1990 + int'(v[13:9]) % ((k == 2) ? 10 : 21);
      if (b == 390) b = 391;
      if (c == 2000) c = 2001;
      wr(ADDR_CTRL, ctrl(n, 3, 0, 100));
      @(posedge i_clk);
      i_accelerating <= (k == 1);
      i_run_cmd <= 1'b1;
      i_decelerating <= (k == 2);
      i_bus_voltage <= 10'(b);
      i_output_current <= 12'(c);
      settle(3);
      chk(o_ramp_cmd, exp_ramp(k, n, c, b));
      if (n != 2) chk(o_chopper_on, 1'b0);
    end
    wr(ADDR_CTRL, ctrl(2, 3, 0, 100));
    chop(400, 1'b1);
    chop(381, 1'b1);
    chop(379, 1'b0);
    chop(389, 1'b0);
    chop(391, 1'b1);
    count_on;
    chk(n, 200);
    wr(ADDR_CTRL, ctrl(2, 3, 1, 100));
    wr(ADDR_STALL_OV, 32'h00000258);
    chop(601, 1'b1);
    chop(586, 1'b1);
    chop(584, 1'b0);
    wr(ADDR_CTRL, ctrl(2, 3, 1, 50));
    @(posedge i_clk);
    i_bus_voltage <= 10'h2BC;
    count_on;
    chk(n >= 50 && n <= 150, 1'b1);
    count_on;
    chk(n, 100);
    chop(0, 1'b0);
    wr(ADDR_COMMAND, 32'h2);
    wr(ADDR_DERATE, {6'h0, 10'h1F4, 1'b0, 15'h07D0});
    for (i = 0; i < 6; i++)
    begin
      v = $random(seed);
      k = (i == 0) ? 3000 : (i == 1) ? 0 : 4 * (int'(v[8:0]) % 500);
      @(posedge i_clk);
      i_output_frequency <= 15'(k);
      settle(2);
      rchk(ADDR_ALLOWED, (k >= 2000) ? 1000 : 500 + k / 4);
    end
    @(posedge i_clk);
    i_run_cmd <= 1'b1;
    i_output_current <= 12'h1F4;
    i_output_frequency <= 15'h01F4;
    {i_accelerating, i_decelerating} <= 2'h0;
    for (k = 0; k < 4; k++)
    begin
      ploss(k, 1'b1, 1'b0, k < 2, 1'b0);
      ploss(k, 1'b0, 1'b1, 1'b0, k == 0 || k == 2);
    end
    for (k = 0; k < 7; k++)
    begin
      @(posedge i_clk);
      i_run_cmd <= (k != 0);
      i_output_current <= (k == 1) ? 12'h0C8 : 12'h1F4;
      i_decelerating <= (k == 2);
      i_output_frequency <= (k == 3) ? 15'h0032 : 15'h01F4;
      i_dc_braking <= (k == 4);
      i_speed_search <= (k == 5);
      i_auto_tuning <= (k == 6);
      ploss(0, k < 3, k >= 3, 1'b0, 1'b0);
    end
    wr(ADDR_COMMAND, 32'h2);
    wr(ADDR_RESET_CFG, 32'h00000202);
    @(posedge i_clk);
    {i_auto_tuning, i_bus_voltage, i_module_temperature} <= {1'b0, 10'h155, 8'h2A};
    flt(6'h05, 1'b1);
    chk(n >= 15 && n <= 24, 1'b1);
    flt(6'h06, 1'b1);
    chk(n >= 15 && n <= 24, 1'b1);
    flt(6'h07, 1'b1);
    chk(n == 60 && o_output_stop, 1'b1);
    rchk(ADDR_HISTORY, 32'h00050607);
    rchk(ADDR_SNAP_BUS, 32'h0000A955);
    rchk(ADDR_STATUS, 32'h00001E81);
    wr(ADDR_COMMAND, 32'h1);
    settle(1);
    chk({o_output_stop, o_error_code}, 0);
    flt(6'h09, 1'b0);
    chk(n, 60);
    wr(ADDR_COMMAND, 32'h1);
    wr(ADDR_RESET_CFG, 32'h00000200);
    flt(6'h05, 1'b1);
    chk(n, 60);
    wr(ADDR_COMMAND, 32'h2);
    rchk(ADDR_HISTORY, 32'h0);
    rchk(ADDR_SNAP_BUS, 32'h0);
    final_report;
  end
endmodule // drive_protection_control_tb
